// [design/dmx_addr.sv]
/*
 * dmx_addr: forms the data address of a banked file access.
 * Assumes the caller registers the result; purely combinational here.
 */
`timescale 1ns/1ns
module dmx_addr
  import dmx_pkg::*;
(
  // address request
  dmx_addr_if.former ai
);

  // ------------------------------------------------------------------
  // address selection
  // ------------------------------------------------------------------
  // indexed mode only for the access bank, low part, extended set on
  always_comb begin
    if (ai.access_sel) begin
      // RQ9 bank from select
      ai.data_addr = {ai.bank, ai.file_addr};
    end else if (ai.ext_en && (ai.file_addr <= DMX_IDX_LIMIT)) begin
      // RQ10 indexed literal offset
      ai.data_addr = DMX_AW'(ai.index_base + {6'h00, ai.file_addr});
    end else if (ai.file_addr <= DMX_IDX_LIMIT) begin
      // RQ9 access bank low
      ai.data_addr = {DMX_ACC_LOW, ai.file_addr};
    end else begin
      ai.data_addr = {DMX_ACC_HIGH, ai.file_addr};  // special registers
    end
  end

endmodule : dmx_addr

// [design/dmx_addr_if.sv]
/*
 * dmx_addr_if: file-address request from the executer to the address
 * former, and the formed 14-bit address back.
 * Assumes both ends sit on the same clock; the path is combinational.
 */
`timescale 1ns/1ns
interface dmx_addr_if;
  import dmx_pkg::*;

  logic [7:0]        file_addr;   // f field of the store
  logic              access_sel;  // a bit
  logic [DMX_BW-1:0] bank;        // live bank select bits
  logic              ext_en;      // extended set enabled
  logic [DMX_AW-1:0] index_base;  // index pointer for literal offset
  logic [DMX_AW-1:0] data_addr;   // formed address

  modport former (
    input  file_addr, access_sel, bank, ext_en, index_base,
    output data_addr
  );
  modport user (
    output file_addr, access_sel, bank, ext_en, index_base,
    input  data_addr
  );
endinterface : dmx_addr_if

// [design/dmx_exec.sv]
/*
 * dmx_exec: executes long-range copy, load-bank literal, load-accumulator
 * literal and store-accumulator-to-file instructions.
 * Assumes the fetch unit offers one program word per cycle with a valid,
 * and the data memory answers a read combinationally in the same cycle
 * in which the read strobe and address stand.
 */
// Contract
// RQ1: copy any 14-bit source to destination, flags untouched
// RQ2: accumulator allowed as copy source or destination
// RQ3: software never targets counter-low or stack-top bytes
// RQ4: copy is three words; read second, write third
// RQ5: load-bank writes six-bit literal, flags untouched
// RQ6: bank select bits seven and six stay zero
// RQ7: 0000 1110 literal loads accumulator, flags untouched
// RQ8: store accumulator into addressed bank byte, flags untouched
// RQ9: access bit zero access bank, one bank select
// RQ10: access zero, extended, f<=95 uses indexed offset
`timescale 1ns/1ns
module dmx_exec
  import dmx_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // program words from fetch
  input  wire logic              instr_valid,
  input  wire logic [DMX_IW-1:0] instr_word,
  // core configuration
  input  wire logic              ext_set_en,
  input  wire logic [DMX_AW-1:0] index_base,
  // data memory read
  output logic                   mem_rd_en,
  output logic      [DMX_AW-1:0] mem_rd_addr,
  input  wire logic [DMX_DW-1:0] mem_rd_data,
  // data memory write
  output logic                   mem_wr_en,
  output logic      [DMX_AW-1:0] mem_wr_addr,
  output logic      [DMX_DW-1:0] mem_wr_data,
  // core registers
  output logic      [DMX_DW-1:0] acc,
  output logic      [DMX_DW-1:0] bank_select_reg,
  output logic                   status_wr,
  output logic                   copy_busy
);

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  dmx_state_t        state;
  logic              is_copy;
  logic              is_ldbank;
  logic              is_ldacc;
  logic              is_stacc;
  logic              word_ok;
  logic [DMX_AW-1:0] op_addr;
  logic              src_is_acc;
  logic [DMX_DW-1:0] copy_byte;
  logic [DMX_DW-1:0] src_byte;

  dmx_addr_if ai ();

  // new instructions are only decoded in the idle state, never between copy words
  assign word_ok   = instr_valid && (state == DMX_ST_IDLE);
  assign is_copy   = word_ok && (instr_word[15:4] == DMX_OP_COPY_W1);
  assign is_ldbank = word_ok && (instr_word[15:6] == DMX_OP_LDBANK);
  // RQ7 load-accumulator decode
  assign is_ldacc  = word_ok && (instr_word[15:8] == DMX_OP_LDACC);
  assign is_stacc  = word_ok && (instr_word[15:9] == DMX_OP_STACC);
  assign op_addr   = instr_word[DMX_COPY_MSB:0];

  // address former for the banked store
  assign ai.file_addr  = instr_word[7:0];
  assign ai.access_sel = instr_word[DMX_ACC_BIT];
  assign ai.bank       = bank_select_reg[DMX_BW-1:0];
  assign ai.ext_en     = ext_set_en;
  assign ai.index_base = index_base;

  dmx_addr u_addr (
    .ai (ai)
  );

  // RQ2 accumulator as copy source; held byte covers a gap before word 3
  assign copy_byte = src_is_acc ? acc :
                     (mem_rd_en ? mem_rd_data : src_byte);

  // ------------------------------------------------------------------
  // long-range copy sequencer
  // ------------------------------------------------------------------
  // RQ4 three word sequence
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= DMX_ST_IDLE;
    end else begin
      unique case (state)
        DMX_ST_IDLE: begin
          if (is_copy) begin
            state <= DMX_ST_SRC;
          end
        end
        DMX_ST_SRC: begin
          if (instr_valid) begin
            state <= DMX_ST_DST;
          end
        end
        DMX_ST_DST: begin
          if (instr_valid) begin
            state <= DMX_ST_IDLE;
          end
        end
        default: state <= DMX_ST_IDLE;  // unused code recovers
      endcase
    end
  end

  // busy flag, kept beside the sequencer for the fetch unit
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      copy_busy <= 1'b0;
    end else if (is_copy) begin
      copy_busy <= 1'b1;
    end else if ((state == DMX_ST_DST) && instr_valid) begin
      copy_busy <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // source read
  // ------------------------------------------------------------------
  // RQ4 read on second word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd_en   <= 1'b0;
      mem_rd_addr <= '0;
      src_is_acc  <= 1'b0;
      src_byte    <= '0;
    end else begin
      mem_rd_en <= (state == DMX_ST_SRC) && instr_valid;
      // memory data only stands with the strobe; keep it for word 3
      if (mem_rd_en) begin
        src_byte <= mem_rd_data;
      end
      if ((state == DMX_ST_SRC) && instr_valid) begin
        mem_rd_addr <= op_addr;
        src_is_acc  <= (op_addr == DMX_ACC_ADDR);
      end
    end
  end

  // ------------------------------------------------------------------
  // data memory write
  // ------------------------------------------------------------------
  // a copy into the accumulator goes to the register, not memory
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
    end else if ((state == DMX_ST_DST) && instr_valid) begin
      // RQ1 write copied byte
      mem_wr_en   <= (op_addr != DMX_ACC_ADDR);
      mem_wr_addr <= op_addr;
      mem_wr_data <= copy_byte;
    end else if (is_stacc) begin
      // RQ8 store accumulator
      mem_wr_en   <= 1'b1;
      mem_wr_addr <= ai.data_addr;
      mem_wr_data <= acc;
    end else begin
      mem_wr_en <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // accumulator
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= DMX_ACC_RST;
    end else if (is_ldacc) begin
      acc <= instr_word[7:0];
    end else if ((state == DMX_ST_DST) && instr_valid &&
                 (op_addr == DMX_ACC_ADDR)) begin
      // RQ2 accumulator as destination
      acc <= copy_byte;
    end
  end

  // ------------------------------------------------------------------
  // bank select
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_select_reg <= DMX_BANK_RST;
    end else if (is_ldbank) begin
      // RQ5 RQ6 literal, top forced
      bank_select_reg <= {DMX_BANK_ZERO, instr_word[DMX_BW-1:0]};
    end
  end

  // ------------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------------
  // none of these instructions touch the flags; the strobe stays low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_wr <= 1'b0;
    end else begin
      status_wr <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_copy_w1;
    is_copy;
  endsequence
  sequence s_copy_rest;
    instr_valid ##1 instr_valid;
  endsequence

  property p_copy_timing;
    s_copy_w1 ##1 s_copy_rest |->
      mem_rd_en && !mem_wr_en ##1 !mem_rd_en;
  endproperty
  a_copy_timing: assert property (p_copy_timing) // RQ4
    else $error("copy read or write in wrong cycle");

  property p_copy_write;
    (state == DMX_ST_DST) && instr_valid && mem_rd_en && !src_is_acc &&
      (op_addr != DMX_ACC_ADDR) |=>
      mem_wr_en && mem_wr_addr == $past(op_addr) &&
      mem_wr_data == $past(mem_rd_data);
  endproperty
  a_copy_write: assert property (p_copy_write) // RQ1
    else $error("copy wrote wrong address or data");

  property p_copy_acc;
    (state == DMX_ST_DST) && instr_valid && src_is_acc |=>
      mem_wr_data == $past(acc);
  endproperty
  a_copy_acc: assert property (p_copy_acc) // RQ2
    else $error("accumulator source not used");

  property p_no_flags;
    !status_wr;
  endproperty
  a_no_flags: assert property (p_no_flags) // RQ1
    else $error("status flags written");

  property p_ldbank;
    is_ldbank |=> bank_select_reg[5:0] == $past(instr_word[5:0]);
  endproperty
  a_ldbank: assert property (p_ldbank) // RQ5
    else $error("bank literal not loaded");

  property p_bank_top;
    bank_select_reg[7:6] == 2'h0;
  endproperty
  a_bank_top: assert property (p_bank_top) // RQ6
    else $error("bank select top bits not zero");

  property p_ldacc;
    instr_valid && !copy_busy && instr_word[15:8] == 8'h0e |=>
      acc == $past(instr_word[7:0]);
  endproperty
  a_ldacc: assert property (p_ldacc) // RQ7
    else $error("accumulator literal not loaded");

  property p_stacc;
    is_stacc |=> mem_wr_en && mem_wr_data == $past(acc);
  endproperty
  a_stacc: assert property (p_stacc) // RQ8
    else $error("accumulator store missing");

  property p_stacc_bank;
    is_stacc && instr_word[8] |=>
      mem_wr_addr == {$past(bank_select_reg[5:0]), $past(instr_word[7:0])};
  endproperty
  a_stacc_bank: assert property (p_stacc_bank) // RQ9
    else $error("banked store address wrong");

  property p_stacc_idx;
    is_stacc && !instr_word[8] && ext_set_en &&
      instr_word[7:0] <= 8'h5f |=>
      mem_wr_addr == $past(index_base) + {6'h00, $past(instr_word[7:0])};
  endproperty
  a_stacc_idx: assert property (p_stacc_idx) // RQ10
    else $error("indexed store address wrong");

endmodule : dmx_exec

// [design/dmx_pkg.sv]
/*
 * dmx_pkg: opcodes, field positions, address constants and states for
 * the data-move instruction executer.
 * Assumes one instruction cycle per mclk edge and a 14-bit data space.
 */
package dmx_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DMX_IW = 16;   // program word
  localparam int DMX_AW = 14;   // data address, 0 to 16383
  localparam int DMX_DW = 8;    // data byte
  localparam int DMX_BW = 6;    // live bank select bits

  // ----------------------------------------------------------------
  // opcode prefixes
  // ----------------------------------------------------------------
  localparam logic [11:0] DMX_OP_COPY_W1 = 12'h006; // word 1, low nibble free
  localparam logic [1:0]  DMX_OP_COPY_WN = 2'h3;    // words 2 and 3 prefix
  localparam logic [9:0]  DMX_OP_LDBANK  = 10'h004; // 0000 0001 00kk kkkk
  localparam logic [7:0]  DMX_OP_LDACC   = 8'h0e;   // 0000 1110 kkkk kkkk
  localparam logic [6:0]  DMX_OP_STACC   = 7'h37;   // 0110 111a ffff ffff

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DMX_ACC_BIT   = 8;                 // access bit of store
  localparam int DMX_COPY_MSB  = 13;                // address field msb

  // ----------------------------------------------------------------
  // addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]        DMX_IDX_LIMIT = 8'h5f; // indexed if f <= this
  localparam logic [DMX_BW-1:0] DMX_ACC_LOW   = 6'h00; // access bank low part
  localparam logic [DMX_BW-1:0] DMX_ACC_HIGH  = 6'h3f; // access bank sfr part
  localparam logic [DMX_AW-1:0] DMX_ACC_ADDR  = 14'h3fe8; // arbitrary value
  localparam logic [DMX_DW-1:0] DMX_ACC_RST   = 8'h00;
  localparam logic [DMX_DW-1:0] DMX_BANK_RST  = 8'h00;
  localparam logic [1:0]        DMX_BANK_ZERO = 2'h0;  // bank bits 7:6

  // ----------------------------------------------------------------
  // long-range copy sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DMX_ST_IDLE,
    DMX_ST_SRC,
    DMX_ST_DST
  } dmx_state_t;

endpackage : dmx_pkg

// [dv/data_move_instruction_exec_tb.sv]
/*
 * data_move_instruction_exec_tb: table of single-word instructions,
 * then copies, reset in mid-copy and back-to-back decode.
 * Assumes the memory model's fill pattern and a 20 ns clock.
 */
`timescale 1ns/1ns
module data_move_instruction_exec_tb
  import dmx_pkg::*;
;
  typedef struct packed {
    logic [15:0] w;
    logic        ext;
    logic [7:0]  acc;
    logic [7:0]  bank;
    logic        wr;
    logic [13:0] adr;
  } dmx_row_t;

  logic mclk, sys_rst, instr_valid, ext_set_en, status_wr, copy_busy;
  logic mem_rd_en, mem_wr_en;
  logic [15:0] instr_word;
  logic [13:0] mem_rd_addr, mem_wr_addr;
  logic [7:0]  mem_rd_data, mem_wr_data, acc, bank_select_reg;
  logic [13:0] index_base;
  int          err_count, total_checks;

  // ordinary cases; index base fixed at 14'h0200
  localparam dmx_row_t ROWS [13] = '{
    '{16'h0e5a, 1'b0, 8'h5a, 8'h00, 1'b0, 14'h0000},
    '{16'h013f, 1'b0, 8'h5a, 8'h3f, 1'b0, 14'h0000},
    '{16'h0100, 1'b0, 8'h5a, 8'h00, 1'b0, 14'h0000},
    '{16'h0125, 1'b0, 8'h5a, 8'h25, 1'b0, 14'h0000},
    '{16'h6f34, 1'b0, 8'h5a, 8'h25, 1'b1, 14'h2534},
    '{16'h6e10, 1'b0, 8'h5a, 8'h25, 1'b1, 14'h0010},
    '{16'h6e5f, 1'b0, 8'h5a, 8'h25, 1'b1, 14'h005f},
    '{16'h6e60, 1'b0, 8'h5a, 8'h25, 1'b1, 14'h3f60},
    '{16'h6e5f, 1'b1, 8'h5a, 8'h25, 1'b1, 14'h025f},
    '{16'h6e60, 1'b1, 8'h5a, 8'h25, 1'b1, 14'h3f60},
    '{16'h0ea5, 1'b1, 8'ha5, 8'h25, 1'b0, 14'h0000},
    '{16'h6fff, 1'b1, 8'ha5, 8'h25, 1'b1, 14'h25ff},
    '{16'h0d12, 1'b0, 8'ha5, 8'h25, 1'b0, 14'h0000}
  };

  dmx_exec uut (.mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .acc(acc),
    .bank_select_reg(bank_select_reg), .status_wr(status_wr),
    .copy_busy(copy_busy));

  dmx_mem_model mem_i (.mclk(mclk), .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr), .rd_data(mem_rd_data), .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr), .wr_data(mem_wr_data));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(logic [13:0] a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'h5a;
  endfunction : pat

  task automatic check(string nm, logic [15:0] exp, logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // drive at falling edge, return one cycle later where effects stand
  task automatic step(logic [15:0] w, logic v);
    instr_word  = w;
    instr_valid = v;
    @(posedge mclk);
    @(negedge mclk);
  endtask : step

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // three-word copy; gap cycles before words two and three just wait
  task automatic copy(logic [13:0] src, logic [13:0] dst, logic gap);
    logic [7:0] acc_before;
    acc_before = acc;
    step(16'h0060, 1'b1);
    check("busy", 16'h1, 16'(copy_busy)); // first cycle busy
    check("rd_en", 16'h0, 16'(mem_rd_en)); // first cycle idle
    if (gap) begin
      step(16'h0e77, 1'b0);
      check("acc", 16'(acc_before), 16'(acc)); // gap keeps state
      check("busy", 16'h1, 16'(copy_busy)); // gap keeps busy
    end
    step({2'h3, src}, 1'b1);
    if (src != DMX_ACC_ADDR) begin
      check("rd_en", 16'h1, 16'(mem_rd_en)); // second cycle read
      check("rd_addr", 16'(src), 16'(mem_rd_addr)); // full source
    end
    check("wr_en", 16'h0, 16'(mem_wr_en)); // no early write
    if (gap) begin
      step(16'h0e77, 1'b0);
      check("rd_en", 16'h0, 16'(mem_rd_en)); // single read strobe
      check("busy", 16'h1, 16'(copy_busy)); // waits for word three
    end
    step({2'h3, dst}, 1'b1);
    check("rd_en", 16'h0, 16'(mem_rd_en)); // no dummy read
    check("busy", 16'h0, 16'(copy_busy)); // cleared after word three
    check("status", 16'h0, 16'(status_wr)); // flags kept
  endtask : copy

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // a hang counts as a mismatch
  initial begin
    #200000;
    err_count++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    index_base = 14'h0200;
    err_count = 0;
    total_checks = 0;
    repeat (8) @(negedge mclk);
    check("acc", 16'h0, 16'(acc)); // cleared in reset
    check("bank", 16'h0, 16'(bank_select_reg)); // cleared in reset
    sys_rst = 1'b0;
    $display("test reset done");
    foreach (ROWS[i]) begin
      ext_set_en = ROWS[i].ext;
      step(ROWS[i].w, 1'b1);
      check("acc", 16'(ROWS[i].acc), 16'(acc)); // literal load
      check("bank", 16'(ROWS[i].bank), 16'(bank_select_reg)); // bank
      check("wr_en", 16'(ROWS[i].wr), 16'(mem_wr_en)); // store strobe
      if (ROWS[i].wr) begin
        check("wr_addr", 16'(ROWS[i].adr), 16'(mem_wr_addr)); // addr
        check("wr_data", 16'(ROWS[i].acc), 16'(mem_wr_data)); // data
      end
      check("status", 16'h0, 16'(status_wr)); // flags kept
    end
    $display("test table done");
    // destinations avoid counter and stack bytes
    copy(14'h2000, 14'h200a, 1'b1);
    check("wr_en", 16'h1, 16'(mem_wr_en)); // copy write
    check("wr_addr", 16'h200a, 16'(mem_wr_addr)); // destination
    check("wr_data", 16'(pat(14'h2000)), 16'(mem_wr_data)); // byte
    copy(14'h3fff, DMX_ACC_ADDR, 1'b0);
    check("acc", 16'(pat(14'h3fff)), 16'(acc)); // acc destination
    check("wr_en", 16'h0, 16'(mem_wr_en)); // no memory write
    copy(DMX_ACC_ADDR, 14'h0000, 1'b0);
    check("wr_data", 16'(pat(14'h3fff)), 16'(mem_wr_data)); // acc source
    check("wr_addr", 16'h0000, 16'(mem_wr_addr)); // bottom address
    step(16'h0e11, 1'b1);
    check("acc", 16'h11, 16'(acc)); // decode right after copy
    $display("test copy done");
    // reset in mid-copy drops the sequence
    step(16'h0060, 1'b1);
    instr_valid = 1'b0;
    sys_rst = 1'b1;
    @(negedge mclk);
    check("busy", 16'h0, 16'(copy_busy)); // abort clears busy
    check("acc", 16'h0, 16'(acc)); // reset value
    sys_rst = 1'b0;
    step(16'h0e3c, 1'b1);
    check("acc", 16'h3c, 16'(acc)); // decode after abort
    step(16'h0000, 1'b0);
    $display("test midreset done");
    finish_test();
  end
endmodule : data_move_instruction_exec_tb

// [dv/dmx_mem_model.sv]
/*
 * dmx_mem_model: data memory seen by the executer's read/write ports.
 * Assumes reads are combinational while the read strobe stands.
 */
`timescale 1ns/1ns
module dmx_mem_model
  import dmx_pkg::*;
(
  // clock
  input  wire logic              mclk,
  // read port
  input  wire logic              rd_en,
  input  wire logic [DMX_AW-1:0] rd_addr,
  output logic      [DMX_DW-1:0] rd_data,
  // write port
  input  wire logic              wr_en,
  input  wire logic [DMX_AW-1:0] wr_addr,
  input  wire logic [DMX_DW-1:0] wr_data
);
  logic [DMX_DW-1:0] mem [2**DMX_AW];
  logic [DMX_DW-1:0] last;

  // address pattern the bench can recompute
  initial begin
    for (int i = 0; i < 2**DMX_AW; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    end
    last = 8'h00;
  end

  // idle bus shows inverse of last byte so a late sample is caught
  always_comb begin
    rd_data = rd_en ? mem[rd_addr] : ~last;
  end

  // writes land on the edge after the strobe stands
  always @(posedge mclk) begin
    if (rd_en) begin
      last <= mem[rd_addr];
    end
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
endmodule : dmx_mem_model
